// File: verilog/mpu_defs.svh
`ifndef MPU_DEFS_SVH
`define MPU_DEFS_SVH

// writable bits of each programming register, all others read as zero
`define BASE_WMASK 32'hffff_ffe0
`define SIZE_WMASK 32'h0000_ff3f
`define ACR_WMASK  32'h0000_173f
`define NUM_WMASK  32'h0000_000f

// field positions
`define BASE_LSB   5
`define EN_BIT     0
`define SIZE_LSB   1
`define SUB_LSB    8
`define AP_LSB     8
`define XN_BIT     12
`define ATTR_W     6

// reset values
`define REG_RST    32'h0000_0000
`define RGN_RST    4'h0

// smallest legal size code (256 bytes); 5'h1f is 4 GB
`define SIZE_MIN   5'h07
`define SIZE_MAX   5'h1f

// permission field encodings
`define AP_NONE    3'h0
`define AP_PRIV_RW 3'h1
`define AP_USER_RO 3'h2
`define AP_FULL    3'h3
`define AP_PRIV_RO 3'h5
`define AP_ALL_RO  3'h6

`endif

// File: verilog/mpu_pkg.sv
package mpu_pkg;

  // which programming register a coprocessor transfer addresses
  typedef enum logic [1:0] {
    SEL_BASE,
    SEL_SIZE,
    SEL_ACR,
    SEL_NUM
  } reg_sel_t;

  typedef logic [31:0] word_t;

endpackage

// File: verilog/region_store.sv
`timescale 1ns/1ps
`include "mpu_defs.svh"

module region_store
  import mpu_pkg::*;
#(
  parameter int NUM_REGIONS = 16
) (
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  input  wire logic                        ce,
  input  wire logic                        wr_en,
  input  wire reg_sel_t                    wr_sel,
  input  wire logic [3:0]                  wr_idx,
  input  wire word_t                       wr_data,
  input  wire logic                        rd_en,
  input  wire logic                        rd_priv,
  input  wire reg_sel_t                    rd_sel,
  input  wire logic [3:0]                  rd_idx,
  output word_t      [NUM_REGIONS-1:0]     base_v,
  output word_t      [NUM_REGIONS-1:0]     size_v,
  output word_t      [NUM_REGIONS-1:0]     acr_v,
  output word_t                            rd_data
);

  typedef struct packed {
    word_t [NUM_REGIONS-1:0] base;
    word_t [NUM_REGIONS-1:0] size;
    word_t [NUM_REGIONS-1:0] acr;
    word_t                   rd;
  } store_t;

  store_t cur;
  store_t next_s;
  logic   wr_ok;
  logic   rd_ok;

  // the region index is four bits wide, so at most sixteen regions fit
  generate
    if (NUM_REGIONS < 1 || NUM_REGIONS > 16) begin : g_bad_count
      $error("NUM_REGIONS out of range for a four-bit index");
    end
  endgenerate

  // indexes past the built region count are dropped on write, read as zero;
  // the number register itself reads back what was written into it, past the count too, on privileged reads
  assign wr_ok = wr_en && (32'(wr_idx) < NUM_REGIONS);
  assign rd_ok = rd_priv && (rd_sel == SEL_NUM || 32'(rd_idx) < NUM_REGIONS);

  // writes land in the selected region; reserved bits never stored
  always_comb begin
    next_s = cur;
    if (wr_ok) begin
      unique case (wr_sel)
        SEL_BASE: next_s.base[wr_idx] = wr_data & `BASE_WMASK;
        SEL_SIZE: next_s.size[wr_idx] = wr_data & `SIZE_WMASK;
        SEL_ACR:  next_s.acr[wr_idx]  = wr_data & `ACR_WMASK;
        SEL_NUM:  next_s.base[wr_idx] = cur.base[wr_idx];
      endcase
    end
    if (rd_en) begin
      next_s.rd = `REG_RST;
      if (rd_ok) begin
        unique case (rd_sel)
          SEL_BASE: next_s.rd = cur.base[rd_idx];
          SEL_SIZE: next_s.rd = cur.size[rd_idx];
          SEL_ACR:  next_s.rd = cur.acr[rd_idx];
          SEL_NUM:  next_s.rd = {28'h0000000, rd_idx};
        endcase
      end
    end
  end

  // every region leaves reset disabled
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cur <= '0;
    end else if (ce) begin
      cur <= next_s;
    end
  end

  assign base_v  = cur.base;
  assign size_v  = cur.size;
  assign acr_v   = cur.acr;
  assign rd_data = cur.rd;

endmodule // region_store

// File: verilog/region_memory_protection_unit.sv
`timescale 1ns/1ps
`include "mpu_defs.svh"

module region_memory_protection_unit
  import mpu_pkg::*;
#(
  parameter int NUM_REGIONS = 16
) (
  input  wire logic              CORE_CLK,
  input  wire logic              RST_N,
  input  wire logic              CE,
  input  wire logic              MPU_ENABLE,
  input  wire logic              REG_WR,
  input  wire logic              REG_RD,
  input  wire logic              REG_PRIV,
  input  wire reg_sel_t          REG_SEL,
  input  wire word_t             REG_WDATA,
  output word_t                  REG_RDATA,
  output logic                   REG_ACK,
  output logic                   REG_ERR,
  input  wire logic              ACC_VALID,
  input  wire word_t             ACC_ADDR,
  input  wire logic              ACC_WRITE,
  input  wire logic              ACC_FETCH,
  input  wire logic              ACC_PRIV,
  input  wire logic              ACC_TCM,
  output logic                   ACC_DONE,
  output logic                   ACC_PERM_FAULT,
  output logic                   ACC_BG_FAULT,
  output logic [`ATTR_W-1:0]     ACC_ATTR,
  output logic                   ACC_HIT,
  output logic [3:0]             ACC_REGION
);

  // only the two documented build sizes are served
  generate
    if (NUM_REGIONS != 12 && NUM_REGIONS != 16) begin : g_bad_count
      $error("NUM_REGIONS must be 12 or 16");
    end
  endgenerate

  typedef struct packed {
    logic [3:0]        rgn;
    logic              done;
    logic              perm_fault;
    logic              bg_fault;
    logic [`ATTR_W-1:0] attr;
    logic              hit;
    logic [3:0]        hit_rgn;
    logic              reg_ack;
    logic              reg_err;
  } state_t;

  state_t                   cur;
  state_t                   next_s;
  word_t [NUM_REGIONS-1:0]  base_v;
  word_t [NUM_REGIONS-1:0]  size_v;
  word_t [NUM_REGIONS-1:0]  acr_v;
  logic  [NUM_REGIONS-1:0]  hit_vec;
  logic                     found;
  logic  [3:0]              win;
  word_t                    win_acr;
  logic                     st_wr;
  logic                     st_rd;

  // permission decode; reserved codes grant nothing
  function automatic logic perm_ok(input logic [2:0] ap, input logic priv, input logic wr);
    logic ok;
    ok = 1'b0;
    case (ap)
      `AP_NONE:    ok = 1'b0;
      `AP_PRIV_RW: ok = priv;
      `AP_USER_RO: ok = priv | !wr;
      `AP_FULL:    ok = 1'b1;
      `AP_PRIV_RO: ok = priv & !wr;
      `AP_ALL_RO:  ok = !wr;
      default:     ok = 1'b0;
    endcase
    return ok;
  endfunction

  // region match; illegal small size codes never match, a safe reading of an unpredictable case
  function automatic logic region_hit(input word_t base, input word_t size, input word_t addr);
    logic [4:0] code;
    word_t      mask;
    word_t      shifted;
    logic [2:0] sub;
    logic       hit;
    code    = size[`SIZE_LSB +: 5];
    mask    = 32'hffff_ffff << ({1'b0, code} + 6'h01);
    shifted = addr >> (code - 5'h02);
    sub     = shifted[2:0];
    hit     = size[`EN_BIT] && (code >= `SIZE_MIN)
              && ((addr & mask) == (base & mask))
              && !size[`SUB_LSB + 32'(sub)];
    return hit;
  endfunction

  region_store #(
    .NUM_REGIONS (NUM_REGIONS)
  ) u_store (
    .clk     (CORE_CLK),
    .rst_n   (RST_N),
    .ce      (CE),
    .wr_en   (st_wr),
    .wr_sel  (REG_SEL),
    .wr_idx  (cur.rgn),
    .wr_data (REG_WDATA),
    .rd_en   (st_rd),
    .rd_priv (REG_PRIV),
    .rd_sel  (REG_SEL),
    .rd_idx  (cur.rgn),
    .base_v  (base_v),
    .size_v  (size_v),
    .acr_v   (acr_v),
    .rd_data (REG_RDATA)
  );

  // base, size and access words always go to the region picked by the number register
  assign st_wr = CE && REG_WR && REG_PRIV && (REG_SEL != SEL_NUM);
  assign st_rd = CE && REG_RD;

  // every region compares in parallel, so one access resolves in one cycle
  generate
    for (genvar g = 0; g < NUM_REGIONS; g++) begin : g_match
      assign hit_vec[g] = region_hit(base_v[g], size_v[g], ACC_ADDR);
    end
  endgenerate

  // later regions override earlier ones
  always_comb begin
    found = 1'b0;
    win   = 4'h0;
    for (int i = 0; i < NUM_REGIONS; i++) begin
      if (hit_vec[i]) begin
        found = 1'b1;
        win   = 4'(i);
      end
    end
    win_acr = acr_v[win];
  end

  // access verdict and register handshake
  always_comb begin
    next_s         = cur;
    next_s.done    = 1'b0;
    next_s.reg_ack = 1'b0;
    next_s.reg_err = 1'b0;
    if (ACC_VALID) begin
      next_s.done       = 1'b1;
      next_s.hit        = found;
      next_s.hit_rgn    = win;
      next_s.perm_fault = 1'b0;
      next_s.bg_fault   = 1'b0;
      next_s.attr       = '0;
      if (MPU_ENABLE) begin
        if (!found) begin
          next_s.bg_fault = 1'b1;
        end else begin
          // a fetch is a read and also needs the execute-never bit clear
          next_s.perm_fault = !perm_ok(win_acr[`AP_LSB +: 3], ACC_PRIV, ACC_WRITE && !ACC_FETCH)
                              || (ACC_FETCH && win_acr[`XN_BIT]);
          next_s.attr       = ACC_TCM ? '0 : win_acr[`ATTR_W-1:0];
        end
      end
    end
    if (REG_WR || REG_RD) begin
      if (!REG_PRIV) begin
        next_s.reg_err = 1'b1;
      end else begin
        next_s.reg_ack = 1'b1;
        if (REG_WR && REG_SEL == SEL_NUM) begin
          next_s.rgn = REG_WDATA[3:0];
        end
      end
    end
  end

  // single state register, frozen while the clock enable is low
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      cur <= '0;
    end else if (CE) begin
      cur <= next_s;
    end
  end

  assign REG_ACK        = cur.reg_ack;
  assign REG_ERR        = cur.reg_err;
  assign ACC_DONE       = cur.done;
  assign ACC_PERM_FAULT = cur.perm_fault;
  assign ACC_BG_FAULT   = cur.bg_fault;
  assign ACC_ATTR       = cur.attr;
  assign ACC_HIT        = cur.hit;
  assign ACC_REGION     = cur.hit_rgn;

  // checks on the verdict path and the register port
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RST_N);

  sequence num_write_s;
    CE && REG_WR && REG_PRIV && REG_SEL == SEL_NUM;
  endsequence

  sequence num_read_s;
    CE && REG_RD && REG_PRIV && REG_SEL == SEL_NUM && !REG_WR;
  endsequence

  sequence checked_s;
    CE && ACC_VALID && MPU_ENABLE;
  endsequence

  acc_done_a: assert property (CE && ACC_VALID |=> ACC_DONE)
    else $error("access not answered next cycle");

  bg_fault_a: assert property (checked_s and (hit_vec == '0) |=> ACC_BG_FAULT && !ACC_PERM_FAULT)
    else $error("unmatched access lacks background fault");

  mpu_off_a: assert property (CE && ACC_VALID && !MPU_ENABLE |=> !ACC_BG_FAULT && !ACC_PERM_FAULT)
    else $error("fault raised while protection is off");

  tcm_attr_a: assert property (CE && ACC_VALID && ACC_TCM |=> ACC_ATTR == '0)
    else $error("tcm access carried region attributes");

  xn_fetch_a: assert property (checked_s and found && ACC_FETCH && win_acr[`XN_BIT] |=> ACC_PERM_FAULT)
    else $error("fetch from execute-never region allowed");

  no_access_a: assert property (checked_s and found && win_acr[`AP_LSB +: 3] == `AP_NONE
                                |=> ACC_PERM_FAULT)
    else $error("no-access region let an access through");

  top_region_a: assert property (checked_s and hit_vec[NUM_REGIONS-1]
                                 |=> ACC_HIT && ACC_REGION == 4'(NUM_REGIONS - 1))
    else $error("highest matching region not chosen");

  unpriv_reg_a: assert property (CE && (REG_WR || REG_RD) && !REG_PRIV |=> REG_ERR && !REG_ACK)
    else $error("unprivileged register access accepted");

  num_echo_a: assert property (num_write_s ##1 num_read_s |=> REG_RDATA == {28'h0000000, $past(REG_WDATA[3:0], 2)})
    else $error("region number not read back");

  base_rsvd_a: assert property (CE && REG_RD && REG_SEL == SEL_BASE |=> REG_RDATA[4:0] == 5'h00)
    else $error("base reserved bits not zero");

  reset_off_a: assert property ($rose(RST_N) |-> hit_vec == '0)
    else $error("region enabled straight out of reset");

  // register answers and what must stay put between requests
  sequence priv_req_s;
    CE && (REG_WR || REG_RD) && REG_PRIV;
  endsequence

  priv_ack_a: assert property (priv_req_s |=> REG_ACK && !REG_ERR)
    else $error("privileged register access not acknowledged");

  rdata_hold_a: assert property (CE && !REG_RD |=> $stable(REG_RDATA))
    else $error("read data changed without a read");

  rgn_hold_a: assert property (!(CE && REG_WR && REG_PRIV && REG_SEL == SEL_NUM) |=> $stable(cur.rgn))
    else $error("region number changed without a write");

  // permission, attribute and background outcomes that a broken decode would get wrong
  user_ro_a: assert property (checked_s and found && !ACC_PRIV && ACC_WRITE && !ACC_FETCH
                              && win_acr[`AP_LSB +: 3] == `AP_USER_RO |=> ACC_PERM_FAULT)
    else $error("user write to read-only region allowed");

  priv_ro_a: assert property (checked_s and found && ACC_WRITE && !ACC_FETCH
                              && win_acr[`AP_LSB +: 3] == `AP_PRIV_RO |=> ACC_PERM_FAULT)
    else $error("write to privileged read-only region allowed");

  full_ok_a: assert property (checked_s and found && win_acr[`AP_LSB +: 3] == `AP_FULL
                              && !(ACC_FETCH && win_acr[`XN_BIT]) |=> !ACC_PERM_FAULT)
    else $error("full-access region raised a permission fault");

  attr_pass_a: assert property (checked_s and found && !ACC_TCM
                                |=> ACC_ATTR == $past(win_acr[`ATTR_W-1:0]))
    else $error("region attributes not passed on");

  bg_nohit_a: assert property (ACC_DONE && ACC_BG_FAULT |-> !ACC_HIT && !ACC_PERM_FAULT)
    else $error("background fault reported beside a region hit");

  // a low enable must freeze the done, attribute, acknowledge and read-data answers, not just the state behind it
  ce_hold_a: assert property (!CE |=> $stable(ACC_DONE) && $stable(ACC_ATTR) && $stable(REG_ACK)
                              && $stable(REG_RDATA))
    else $error("outputs moved while the clock enable was low");

endmodule // region_memory_protection_unit

// File: verification/core_access_model.sv
`timescale 1ns/1ps

module core_access_model
  import mpu_pkg::*;
(
  input  wire logic clk,
  output logic      acc_valid,
  output word_t     acc_addr,
  output logic      acc_write,
  output logic      acc_fetch,
  output logic      acc_priv,
  output logic      acc_tcm
);
  initial {acc_valid, acc_addr, acc_write, acc_fetch, acc_priv, acc_tcm} = '0;

  // loads, stores and fetches only: no floating-point register traffic is ever made
  // one access per call, held across exactly one sampling edge
  task automatic issue(input word_t a, input logic [3:0] k);
    {acc_valid, acc_addr, acc_write, acc_fetch, acc_priv, acc_tcm} = {1'b1, a, k};
    @(posedge clk);
    #1;
  endtask

  // released bus shows the inverse so a stale address never looks live
  task automatic idle();
    acc_valid = 1'b0;
    acc_addr  = ~acc_addr;
  endtask
endmodule // core_access_model

// File: verification/region_memory_protection_unit_tb.sv
`timescale 1ns/1ps
`include "mpu_defs.svh"

module region_memory_protection_unit_tb
  import mpu_pkg::*;
;
  localparam int NR = 12;
  logic        clk = 0, rst_n = 0, mpu_on = 0, reg_wr = 0, reg_rd = 0, reg_priv = 0, ce = 1;
  reg_sel_t    reg_sel = SEL_BASE;
  word_t       reg_wdata = '0, rdata, aa;
  logic        ack, err, done, perm, bg, hit, av, aw, af, apv, at;
  logic [5:0]  attr;
  logic [3:0]  rgn, snum = '0;
  word_t       sb[16] = '{default: '0}, ss[16] = '{default: '0}, sa[16] = '{default: '0};
  logic [33:0] rq[$];
  logic [12:0] aq[$];
  int          n_mismatch = 0, n_checks = 0;
  integer      seed = 17;

  // 100 MHz core clock
  always #5 clk = ~clk;

  region_memory_protection_unit #(.NUM_REGIONS(NR)) i_region_memory_protection_unit (
    .CORE_CLK(clk), .RST_N(rst_n), .CE(ce), .MPU_ENABLE(mpu_on), .REG_WR(reg_wr), .REG_RD(reg_rd),
    .REG_PRIV(reg_priv), .REG_SEL(reg_sel), .REG_WDATA(reg_wdata), .REG_RDATA(rdata), .REG_ACK(ack),
    .REG_ERR(err), .ACC_VALID(av), .ACC_ADDR(aa), .ACC_WRITE(aw), .ACC_FETCH(af), .ACC_PRIV(apv),
    .ACC_TCM(at), .ACC_DONE(done), .ACC_PERM_FAULT(perm), .ACC_BG_FAULT(bg), .ACC_ATTR(attr),
    .ACC_HIT(hit), .ACC_REGION(rgn));

  core_access_model i_core_access_model (.clk(clk), .acc_valid(av), .acc_addr(aa), .acc_write(aw),
    .acc_fetch(af), .acc_priv(apv), .acc_tcm(at));

  task automatic chk(input string what, input logic [39:0] e, input logic [39:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // register request; a same-cycle read sees the old contents, so expect before updating
  task automatic rop(input logic w, input logic r, input logic p, input reg_sel_t s, input word_t d);
    word_t m, e;
    m = s == SEL_BASE ? `BASE_WMASK : s == SEL_SIZE ? `SIZE_WMASK : s == SEL_ACR ? `ACR_WMASK : `NUM_WMASK;
    e = s == SEL_NUM ? {28'h0, snum} : snum >= NR ? '0 : s == SEL_BASE ? sb[snum] : s == SEL_SIZE ? ss[snum] : sa[snum];
    if (w || r) rq.push_back({r, !p, p ? e : 32'h0});
    if (w && p && s == SEL_NUM) snum = d[3:0];
    else if (w && p && snum < NR) begin
      if (s == SEL_BASE) sb[snum] = d & m;
      else if (s == SEL_SIZE) ss[snum] = d & m;
      else sa[snum] = d & m;
    end
    {reg_wr, reg_rd, reg_priv, reg_sel, reg_wdata} = {w, r, p, s, d};
    @(posedge clk);
    #1;
  endtask

  // reference verdict from the shadow copy; k is {write, fetch, priv, tcm}
  function automatic logic [12:0] pred(input word_t a, input logic [3:0] k);
    logic h, ok, wr;
    logic [3:0] r;
    logic [4:0] c;
    logic [63:0] m;
    logic [2:0] ap;
    h = 0;
    r = 0;
    for (int i = 0; i < NR; i++) begin
      c = ss[i][5:1];
      m = ~((64'h1 << (c + 6'd1)) - 1);
      if (ss[i][0] && c >= 7 && ((a ^ sb[i]) & m[31:0]) == 0 && !ss[i][8 + ((a >> (c - 5'd2)) & 32'h7)]) begin
        h = 1;
        r = i[3:0];
      end
    end
    ap = sa[r][10:8];
    wr = k[3] && !k[2];
    ok = wr ? (k[1] ? ap inside {1, 2, 3} : ap == 3) : (k[1] ? ap inside {1, 2, 3, 5, 6} : ap inside {2, 3, 6});
    if (k[2] && sa[r][12]) ok = 0;
    return {mpu_on && h && !ok, mpu_on && !h, (mpu_on && h && !k[0]) ? sa[r][5:0] : 6'h0, h, h ? r : 4'h0};
  endfunction

  task automatic aop(input word_t a, input logic [3:0] k);
    aq.push_back(pred(a, k));
    i_core_access_model.issue(a, k);
  endtask

  // answers are settled 2 ns after the edge; oldest note is compared
  always @(posedge clk) begin : watch
    logic [33:0] e;
    logic [12:0] v;
    #2;
    if (ack === 1'b1 || err === 1'b1) begin
      e = rq.size() ? rq.pop_front() : 'x;
      chk("reg answer", {7'h0, e[32], e[33] ? e[31:0] : 32'h0},
          {7'h0, err, e[33] ? rdata : 32'h0});
    end
    if (done === 1'b1) begin
      v = aq.size() ? aq.pop_front() : 'x;
      chk("verdict", {27'h0, v},
          {27'h0, perm, bg, attr, hit, hit ? rgn : 4'h0});
    end
  end

  // main sequence: reset readback, three programming rounds, refusals
  initial begin : main
    int c, j;
    word_t a, d;
    logic [63:0] m;
    logic [3:0] k;
    logic t;
    repeat (6) @(posedge clk);
    #1;
    rst_n = 1;
    for (int i = 0; i < NR; i++) begin
      rop(1, 0, 1, SEL_NUM, i);
      for (int s = 0; s < 3; s++) rop(0, 1, 1, reg_sel_t'(s), '0);
    end
    for (int round = 0; round < 3; round++) begin
      mpu_on = round != 1;
      for (int i = 0; i < NR; i++) begin
        c = 7 + {$random(seed)} % 25;
        m = (64'h1 << (c + 1)) - 1;
        d = $random(seed);
        d[5:1] = c[4:0];
        d[0] = ($random(seed) & 3) != 0;
        rop(1, 0, 1, SEL_NUM, i);
        rop(1, 0, 1, SEL_BASE, word_t'($random(seed)) & ~m[31:0]);
        rop(1, 0, 1, SEL_SIZE, d);
        rop(1, 0, 1, SEL_ACR, $random(seed));
        for (int s = 0; s < 3; s++) rop(0, 1, 1, reg_sel_t'(s), '0);
      end
      rop(0, 0, 0, SEL_BASE, '0);
      for (int n = 0; n < 200; n++) begin
        j = {$random(seed)} % NR;
        k = 4'($random(seed));
        m = (64'h1 << (ss[j][5:1] + 6'd1)) - 1;
        t = k[0] & ss[j][0];
        a = $random(seed);
        if (t) a = sb[j] | (a & m[31:0]);
        aop(a, {k[3:1], t & a[0]});
      end
      // one frozen cycle: the last verdict must stand unchanged, so it is seen twice
      i_core_access_model.idle();
      aq.push_back(aq[$]);
      ce = 1'b0;
      @(posedge clk);
      #1;
      ce = 1'b1;
    end
    rop(1, 0, 0, SEL_NUM, 32'h2);
    rop(0, 1, 0, SEL_BASE, '0);
    rop(0, 1, 1, SEL_NUM, '0);
    rop(1, 0, 1, SEL_NUM, 32'hd);
    rop(0, 1, 1, SEL_NUM, '0);
    rop(1, 0, 1, SEL_BASE, '1);
    rop(0, 1, 1, SEL_BASE, '0);
    rop(0, 1, 1, SEL_NUM, '0);
    rop(0, 0, 0, SEL_BASE, '0);
    repeat (3) @(posedge clk);
    chk("pending", 40'h0, 40'(rq.size() + aq.size()));
    wrap_up();
  end

  // watchdog: the run needs about 1000 cycles
  initial begin
    #200000;
    n_mismatch++;
    wrap_up();
  end
endmodule // region_memory_protection_unit_tb
